// ### inc/cswf_defs.svh
// Purpose: Register offsets, field positions, reset values and counts of the selective wake filter
// Assumes: 7-bit register address, 8-bit register data
// Notes: Definitions only
`ifndef CSWF_DEFS_SVH
`define CSWF_DEFS_SVH

// ==========================================================
// Register offsets
`define CSWF_ADDR_RATE 7'h26
`define CSWF_ADDR_ID0 7'h27
`define CSWF_ADDR_ID1 7'h28
`define CSWF_ADDR_ID2 7'h29
`define CSWF_ADDR_ID3 7'h2A
`define CSWF_ADDR_MASK0 7'h2B
`define CSWF_ADDR_MASK1 7'h2C
`define CSWF_ADDR_MASK2 7'h2D
`define CSWF_ADDR_MASK3 7'h2E
`define CSWF_ADDR_FRAME_CTRL 7'h2F
`define CSWF_ADDR_STATUS 7'h7E

// ==========================================================
// Writable bits, reserved bits read as zero
`define CSWF_RATE_WMASK 8'h07
`define CSWF_ID3_WMASK 8'h1F
`define CSWF_FC_WMASK 8'hCF

// ==========================================================
// Field positions
`define CSWF_FC_EXT_BIT 7
`define CSWF_FC_DATA_BIT 6
`define CSWF_DLC_MAX_BYTES 4'h8

// ==========================================================
// Reset values
`define CSWF_RATE_RESET 8'h05
`define CSWF_ID_RESET 8'h00
`define CSWF_MASK_RESET 8'h00
`define CSWF_FC_RESET 8'h40

// ==========================================================
// Frame error counter
`define CSWF_ERR_LIMIT 6'h1F
`define CSWF_ERR_WIDTH 6

`endif

// ### inc/cswf_pkg.sv
// Purpose: Types of the selective wake filter
// Assumes: cswf_defs.svh for widths
// Notes: No imports anywhere, always scoped
`include "cswf_defs.svh"

package cswf_pkg;

  // ==========================================================
  // Receive-side state
  typedef enum logic {
    CSWF_RX_LISTEN,
    CSWF_RX_IGNORE
  } cswf_rx_state_t;

  // ==========================================================
  // Top-level state
  typedef struct packed {
    logic [7:0] rate_sel;
    logic [7:0] id0;
    logic [7:0] id1;
    logic [7:0] id2;
    logic [7:0] id3;
    logic [7:0] mask0;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] mask3;
    logic [7:0] frame_ctrl;
    logic cfg_valid;
    logic err_flag;
    logic wake;
    logic wake_frame;
    cswf_rx_state_t rx;
    logic [7:0] rdata;
    logic [10:0] rate_kbps;
    logic [3:0] exp_bytes;
  } cswf_state_t;

  // ==========================================================
  // Error counter state
  typedef struct packed {
    logic [`CSWF_ERR_WIDTH-1:0] count;
    logic overflow;
  } cswf_cnt_state_t;

endpackage : cswf_pkg

// ### verilog/cswf_err_counter.sv
// Purpose: Up/down frame error counter with overflow pulse
// Assumes: Increment and decrement are never both high
// Notes: Holds above the limit until cleared, so a second overflow needs a restart
`timescale 1ns/1ps
`default_nettype none
`include "cswf_defs.svh"

module cswf_err_counter #(
  parameter logic [`CSWF_ERR_WIDTH-1:0] LIMIT = `CSWF_ERR_LIMIT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Count control
  input wire logic inc,
  input wire logic dec,
  input wire logic clear,
  // Result
  output logic [`CSWF_ERR_WIDTH-1:0] count,
  output logic overflow
);

  cswf_pkg::cswf_cnt_state_t s;
  cswf_pkg::cswf_cnt_state_t next_s;

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.overflow = 1'b0;
    if (clear) begin
      next_s.count = '0;
    end else if (inc && s.count <= LIMIT) begin
      next_s.count = s.count + 1'b1;
      next_s.overflow = (s.count == LIMIT);
    end else if (dec && s.count != '0 && s.count <= LIMIT) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign count = s.count;
  assign overflow = s.overflow;

endmodule : cswf_err_counter
`default_nettype wire

// ### verilog/cswf_top.sv
// Purpose: Selective wake filter configuration and FD tolerance
// Assumes: Frame decoder on the same clock delivers one-cycle frame events
// Notes: Data mask registers and data comparison live outside; rx_data_hit carries the result
//
// Summary of operation
// - FD tolerance on: FD control field decrements error counter, stay asleep.
// - An FD frame is never a valid wake frame.
// - After an FD control field, ignore the bus until idle.
// - FD tolerance off: FD frame counts as erroneous, counter increments.
// - Counter overflow by FD frames sets frame detect error and wakes.
// - Rate code maps to 50..1000 kbit/s; codes 100, 101 and 110 give 500.
// - Extended identifier assembled from the four pattern bytes.
// - Standard identifier from pattern byte 2 bits 7:2 and byte 3 bits 4:0.
// - Mask bytes use the same layout as pattern bytes.
// - Standard mask from mask byte 2 bits 7:2 and byte 3 bits 4:0.
// - Frame control bit 7 selects standard or extended identifier.
// - Frame control bit 6 enables length and data evaluation.
// - Frame control bits 3:0 give expected data length 0 to 8.
// - Length codes 9 to 15 mean eight bytes expected.
// - Any configuration write clears the configuration valid flag.
// - Counter up for erroneous frame, down for clean frame.
// - Counter above 31 sets frame detect error and wakes.
// - Mask bit one makes the identifier bit a don't care.
`timescale 1ns/1ps
`default_nettype none
`include "cswf_defs.svh"

module cswf_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access
  input wire logic reg_wr,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Control from the rest of the device
  input wire logic selective_wake_active,
  input wire logic fd_tolerance_enable,
  input wire logic filter_config_set,
  input wire logic frame_error_clear,
  input wire logic pn_restart,
  // Frame decoder events
  input wire logic fd_ctrl_field,
  input wire logic frame_end,
  input wire logic frame_error,
  input wire logic rx_extended,
  input wire logic [28:0] rx_id,
  input wire logic rx_remote,
  input wire logic [3:0] rx_dlc,
  input wire logic rx_data_hit,
  input wire logic bus_idle,
  // Status
  output logic filter_config_valid,
  output logic frame_detect_error_flag,
  output logic wake_request,
  output logic wake_frame_valid,
  output logic fd_ignoring,
  output logic [10:0] arbitration_rate_kbps,
  output logic [3:0] expected_bytes,
  output logic [`CSWF_ERR_WIDTH-1:0] err_count
);

  // ==========================================================
  // Helpers
  function automatic logic [10:0] rate_kbps(input logic [2:0] code);
    case (code)
      3'b000: rate_kbps = 11'h032;
      3'b001: rate_kbps = 11'h064;
      3'b010: rate_kbps = 11'h07D;
      3'b011: rate_kbps = 11'h0FA;
      3'b111: rate_kbps = 11'h3E8;
      default: rate_kbps = 11'h1F4;                 // Reserved codes act as 500
    endcase
  endfunction : rate_kbps

  // Same layout serves pattern and mask
  function automatic logic [28:0] assemble_id(input logic [7:0] b0, input logic [7:0] b1,
                                              input logic [7:0] b2, input logic [7:0] b3,
                                              input logic ext);
    if (ext) begin
      assemble_id = {b3[4:0], b2[7:2], b2[1:0], b1, b0};
    end else begin
      assemble_id = {18'h0_0000, b3[4:0], b2[7:2]};
    end
  endfunction : assemble_id

  // Codes above eight still expect eight bytes
  function automatic logic [3:0] dlc_bytes(input logic [3:0] code);
    dlc_bytes = (code > `CSWF_DLC_MAX_BYTES) ? `CSWF_DLC_MAX_BYTES : code;
  endfunction : dlc_bytes

  function automatic logic is_config(input logic [6:0] addr);
    is_config = (addr >= `CSWF_ADDR_RATE) && (addr <= `CSWF_ADDR_FRAME_CTRL);
  endfunction : is_config

  // ==========================================================
  // State
  cswf_pkg::cswf_state_t s;
  cswf_pkg::cswf_state_t next_s;
  logic cnt_inc;
  logic cnt_dec;
  logic cnt_overflow;
  logic ext_sel;
  logic data_sel;
  logic [28:0] id_pat;
  logic [28:0] id_mask;
  logic id_match;
  logic data_ok;
  logic listening;

  assign ext_sel = s.frame_ctrl[`CSWF_FC_EXT_BIT];
  assign data_sel = s.frame_ctrl[`CSWF_FC_DATA_BIT];
  assign id_pat = assemble_id(s.id0, s.id1, s.id2, s.id3, ext_sel);
  assign id_mask = assemble_id(s.mask0, s.mask1, s.mask2, s.mask3, ext_sel);
  // Mask one means don't care; format must agree too
  assign id_match = (rx_extended == ext_sel) && (((rx_id ^ id_pat) & ~id_mask) == 29'h0000_0000);
  assign data_ok = !rx_remote && (dlc_bytes(rx_dlc) == dlc_bytes(s.frame_ctrl[3:0]))
                   && (s.frame_ctrl[3:0] == 4'h0 || rx_data_hit);
  assign listening = selective_wake_active && (s.rx == cswf_pkg::CSWF_RX_LISTEN);

  // FD control field outranks a frame end in the same cycle
  assign cnt_inc = listening && ((fd_ctrl_field && !fd_tolerance_enable)
                   || (!fd_ctrl_field && frame_end && frame_error));
  assign cnt_dec = listening && ((fd_ctrl_field && fd_tolerance_enable)
                   || (!fd_ctrl_field && frame_end && !frame_error));

  cswf_err_counter #(
    .LIMIT(`CSWF_ERR_LIMIT)
  ) u_err_counter (
    .clk(clk),
    .rst(rst),
    .inc(cnt_inc),
    .dec(cnt_dec),
    .clear(pn_restart),
    .count(err_count),
    .overflow(cnt_overflow)
  );

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.wake_frame = 1'b0;
    // Register writes, reserved bits forced to zero
    if (reg_wr) begin
      case (reg_addr)
        `CSWF_ADDR_RATE: next_s.rate_sel = reg_wdata & `CSWF_RATE_WMASK;
        `CSWF_ADDR_ID0: next_s.id0 = reg_wdata;
        `CSWF_ADDR_ID1: next_s.id1 = reg_wdata;
        `CSWF_ADDR_ID2: next_s.id2 = reg_wdata;
        `CSWF_ADDR_ID3: next_s.id3 = reg_wdata & `CSWF_ID3_WMASK;
        `CSWF_ADDR_MASK0: next_s.mask0 = reg_wdata;
        `CSWF_ADDR_MASK1: next_s.mask1 = reg_wdata;
        `CSWF_ADDR_MASK2: next_s.mask2 = reg_wdata;
        `CSWF_ADDR_MASK3: next_s.mask3 = reg_wdata & `CSWF_ID3_WMASK;
        `CSWF_ADDR_FRAME_CTRL: next_s.frame_ctrl = reg_wdata & `CSWF_FC_WMASK;
        default: ;
      endcase
    end
    // A config write in the same cycle beats the software set
    if (filter_config_set) begin
      next_s.cfg_valid = 1'b1;
    end
    if (reg_wr && is_config(reg_addr)) begin
      next_s.cfg_valid = 1'b0;
    end
    // Overflow set wins over a clear in the same cycle
    if (frame_error_clear) begin
      next_s.err_flag = 1'b0;
    end
    if (pn_restart) begin
      next_s.wake = 1'b0;
    end
    if (cnt_overflow) begin
      next_s.err_flag = 1'b1;
      next_s.wake = 1'b1;
    end
    // Receive side
    case (s.rx)
      cswf_pkg::CSWF_RX_LISTEN: begin
        if (selective_wake_active && fd_ctrl_field) begin
          next_s.rx = cswf_pkg::CSWF_RX_IGNORE;
        end else if (selective_wake_active && s.cfg_valid && frame_end && !frame_error
                     && id_match && (!data_sel || data_ok)) begin
          next_s.wake_frame = 1'b1;
          next_s.wake = 1'b1;
        end
      end
      cswf_pkg::CSWF_RX_IGNORE: begin
        // FD frame ends here without any wake decision
        if (bus_idle) begin
          next_s.rx = cswf_pkg::CSWF_RX_LISTEN;
        end
      end
      default: next_s.rx = cswf_pkg::CSWF_RX_LISTEN;
    endcase
    // Derived outputs, one cycle behind the registers
    next_s.rate_kbps = rate_kbps(s.rate_sel[2:0]);
    next_s.exp_bytes = dlc_bytes(s.frame_ctrl[3:0]);
    case (reg_addr)
      `CSWF_ADDR_RATE: next_s.rdata = s.rate_sel;
      `CSWF_ADDR_ID0: next_s.rdata = s.id0;
      `CSWF_ADDR_ID1: next_s.rdata = s.id1;
      `CSWF_ADDR_ID2: next_s.rdata = s.id2;
      `CSWF_ADDR_ID3: next_s.rdata = s.id3;
      `CSWF_ADDR_MASK0: next_s.rdata = s.mask0;
      `CSWF_ADDR_MASK1: next_s.rdata = s.mask1;
      `CSWF_ADDR_MASK2: next_s.rdata = s.mask2;
      `CSWF_ADDR_MASK3: next_s.rdata = s.mask3;
      `CSWF_ADDR_FRAME_CTRL: next_s.rdata = s.frame_ctrl;
      `CSWF_ADDR_STATUS: next_s.rdata = {4'h0, s.rx == cswf_pkg::CSWF_RX_IGNORE, s.wake, s.err_flag, s.cfg_valid};
      default: next_s.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.rate_sel <= `CSWF_RATE_RESET;
      s.id0 <= `CSWF_ID_RESET;
      s.id1 <= `CSWF_ID_RESET;
      s.id2 <= `CSWF_ID_RESET;
      s.id3 <= `CSWF_ID_RESET;
      s.mask0 <= `CSWF_MASK_RESET;
      s.mask1 <= `CSWF_MASK_RESET;
      s.mask2 <= `CSWF_MASK_RESET;
      s.mask3 <= `CSWF_MASK_RESET;
      s.frame_ctrl <= `CSWF_FC_RESET;
      s.rx <= cswf_pkg::CSWF_RX_LISTEN;
      s.rate_kbps <= 11'h1F4;
      s.exp_bytes <= 4'h0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign filter_config_valid = s.cfg_valid;
  assign frame_detect_error_flag = s.err_flag;
  assign wake_request = s.wake;
  assign wake_frame_valid = s.wake_frame;
  assign fd_ignoring = (s.rx == cswf_pkg::CSWF_RX_IGNORE);
  assign arbitration_rate_kbps = s.rate_kbps;
  assign expected_bytes = s.exp_bytes;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  fd_tol_dec_a: assert property (
    listening && fd_ctrl_field && fd_tolerance_enable && !pn_restart
    && err_count != 6'h00 && err_count <= 6'h1F
    |=> err_count == $past(err_count) - 6'h01 && !wake_frame_valid)
    else $error("FD frame with tolerance did not decrement the counter");

  fd_no_wake_a: assert property (
    selective_wake_active && fd_ctrl_field |=> !wake_frame_valid [*2])
    else $error("FD frame produced a wake frame");

  fd_ignore_a: assert property (
    listening && fd_ctrl_field |=> fd_ignoring)
    else $error("Bus not ignored after FD control field");

  ignore_hold_a: assert property (
    fd_ignoring && !bus_idle |=> fd_ignoring && !wake_frame_valid)
    else $error("Ignore state left before bus idle");

  fd_err_inc_a: assert property (
    listening && fd_ctrl_field && !fd_tolerance_enable && !pn_restart && err_count < 6'h1F
    |=> err_count == $past(err_count) + 6'h01)
    else $error("FD frame without tolerance did not increment the counter");

  overflow_wake_a: assert property (
    cnt_inc && !pn_restart && err_count == 6'h1F
    |=> err_count == 6'h20 ##1 frame_detect_error_flag && wake_request)
    else $error("Counter overflow did not raise the error flag and wake");

  rate_reserved_a: assert property (
    reg_wr && reg_addr == `CSWF_ADDR_RATE && reg_wdata[2:0] == 3'b110
    |=> ##1 arbitration_rate_kbps == 11'h1F4)
    else $error("Reserved rate code does not act as 500 kbit/s");

  cfg_clear_a: assert property (
    reg_wr && is_config(reg_addr) |=> !filter_config_valid)
    else $error("Configuration write left the valid flag set");

  long_dlc_a: assert property (
    reg_wr && reg_addr == `CSWF_ADDR_FRAME_CTRL && reg_wdata[3:0] > 4'h8
    |=> ##1 expected_bytes == 4'h8)
    else $error("Long length code not taken as eight bytes");

  data_filter_a: assert property (
    wake_frame_valid && $past(data_sel) |-> !$past(rx_remote))
    else $error("Remote frame accepted with data filtering on");

  ignore_exit_a: assert property (
    fd_ignoring && bus_idle |=> !fd_ignoring)
    else $error("Ignore state kept after bus idle");

  ignore_frozen_a: assert property (
    fd_ignoring && !pn_restart |=> $stable(err_count) && !wake_frame_valid)
    else $error("Counter or wake moved while ignoring the bus");

  rate_top_a: assert property (
    reg_wr && reg_addr == `CSWF_ADDR_RATE && reg_wdata[2:0] == 3'b111
    |=> ##1 arbitration_rate_kbps == 11'h3E8)
    else $error("Rate code 111 does not give 1000 kbit/s");

  rate_low_a: assert property (
    reg_wr && reg_addr == `CSWF_ADDR_RATE && reg_wdata[2:0] == 3'b000
    |=> ##1 arbitration_rate_kbps == 11'h032)
    else $error("Rate code 000 does not give 50 kbit/s");

  clean_dec_a: assert property (
    listening && frame_end && !frame_error && !fd_ctrl_field && !pn_restart
    && err_count != 6'h00 && err_count <= 6'h1F
    |=> err_count == $past(err_count) - 6'h01)
    else $error("Clean frame did not decrement the counter");

  err_inc_a: assert property (
    listening && frame_end && frame_error && !fd_ctrl_field && !pn_restart && err_count < 6'h1F
    |=> err_count == $past(err_count) + 6'h01)
    else $error("Erroneous frame did not increment the counter");

  flag_sticky_a: assert property (
    frame_detect_error_flag && !frame_error_clear |=> frame_detect_error_flag)
    else $error("Frame detect error flag dropped without a clear");

  wake_sticky_a: assert property (
    wake_request && !pn_restart |=> wake_request)
    else $error("Wake request dropped without a restart");

  wake_format_a: assert property (
    wake_frame_valid |-> $past(rx_extended) == $past(ext_sel))
    else $error("Wake frame of the wrong identifier format");

  wake_cfg_a: assert property (
    wake_frame_valid |-> $past(filter_config_valid))
    else $error("Wake frame accepted with configuration not valid");

  cov_fd_tol_c: cover property (listening && fd_ctrl_field && fd_tolerance_enable ##1 fd_ignoring);
  cov_overflow_c: cover property (cnt_overflow ##1 frame_detect_error_flag);
  cov_wake_frame_c: cover property (wake_frame_valid);
  cov_ignore_exit_c: cover property (fd_ignoring ##1 !fd_ignoring);
  cov_data_wake_c: cover property (wake_frame_valid && $past(data_sel));

endmodule : cswf_top
`default_nettype wire

// ### sim/cswf_bus_node.sv
// Purpose: Other nodes on the bus, seen through the frame decoder events
// Assumes: Tasks are entered just after a rising edge
// Notes: Fields are valid only with frame_end, zero before the first frame and inverted after each frame
`timescale 1ns/1ps
`default_nettype none

module cswf_bus_node (
  // Clock
  input wire logic clk,
  // Decoder events
  output logic fd_ctrl_field,
  output logic frame_end,
  output logic frame_error,
  output logic rx_extended,
  output logic [28:0] rx_id,
  output logic rx_remote,
  output logic [3:0] rx_dlc,
  output logic rx_data_hit,
  output logic bus_idle
);
  initial begin
    {fd_ctrl_field, frame_end, frame_error, rx_extended, rx_id, rx_remote, rx_dlc, rx_data_hit} = '0;
    bus_idle = 1'b1;
  end

  // ==========================================================
  // Classic frame
  task automatic frame(input logic e, input logic [28:0] id, input logic rem, input logic [3:0] dlc,
                       input logic hit, input logic err);
    bus_idle = 1'b0;
    frame_end = 1'b1;
    {frame_error, rx_extended, rx_id, rx_remote, rx_dlc, rx_data_hit} = {err, e, id, rem, dlc, hit};
    @(posedge clk);
    #2;
    // Stale fields must never look valid
    {frame_error, rx_extended, rx_id, rx_remote, rx_dlc, rx_data_hit} = ~{err, e, id, rem, dlc, hit};
    frame_end = 1'b0;
    bus_idle = 1'b1;
    @(posedge clk);
    #2;
  endtask : frame

  // ==========================================================
  // FD frame, fast phase at most eight times the arbitration rate
  task automatic fd_frame(input logic e, input logic [28:0] id, input logic [3:0] dlc);
    bus_idle = 1'b0;
    fd_ctrl_field = 1'b1;
    @(posedge clk);
    #2;
    fd_ctrl_field = 1'b0;
    // Matching, error-free end: only the ignore state keeps it from waking
    frame_end = 1'b1;
    {frame_error, rx_extended, rx_id, rx_remote, rx_dlc, rx_data_hit} = {1'b0, e, id, 1'b0, dlc, 1'b1};
    @(posedge clk);
    #2;
    frame_end = 1'b0;
    {frame_error, rx_extended, rx_id, rx_remote, rx_dlc, rx_data_hit} = ~{1'b0, e, id, 1'b0, dlc, 1'b1};
  endtask : fd_frame

  task automatic idle();
    bus_idle = 1'b1;
    repeat (3) @(posedge clk);
    #2;
  endtask : idle
endmodule : cswf_bus_node
`default_nettype wire

// ### sim/tb_cswf_top.sv
// Purpose: Self-checking bench of the selective wake filter
// Assumes: Inputs change 2 ns after the rising edge
// Notes: Random values from a fixed LFSR seed, corner cases by hand
`timescale 1ns/1ps
`default_nettype none
`include "cswf_defs.svh"

module tb_cswf_top;
  // ==========================================================
  // Signals
  logic clk, rst, reg_wr, selective_wake_active, fd_tolerance_enable;
  logic filter_config_set, frame_error_clear, pn_restart;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic fd_ctrl_field, frame_end, frame_error, rx_extended, rx_remote, rx_data_hit, bus_idle;
  logic [28:0] rx_id;
  logic [3:0] rx_dlc, expected_bytes;
  logic filter_config_valid, frame_detect_error_flag, wake_request, wake_frame_valid, fd_ignoring;
  logic [10:0] arbitration_rate_kbps;
  logic [5:0] err_count;
  int err_total = 0, n_checks = 0, wakes = 0;
  logic [31:0] seed;
  logic [10:0] rates [8] = '{11'h032, 11'h064, 11'h07D, 11'h0FA, 11'h1F4, 11'h1F4, 11'h1F4, 11'h3E8};

  cswf_top cswf_top_inst (
    .clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .selective_wake_active, .fd_tolerance_enable,
    .filter_config_set, .frame_error_clear, .pn_restart, .fd_ctrl_field, .frame_end, .frame_error, .rx_extended,
    .rx_id, .rx_remote, .rx_dlc, .rx_data_hit, .bus_idle, .filter_config_valid, .frame_detect_error_flag,
    .wake_request, .wake_frame_valid, .fd_ignoring, .arbitration_rate_kbps, .expected_bytes, .err_count
  );
  cswf_bus_node cswf_bus_node_inst (
    .clk, .fd_ctrl_field, .frame_end, .frame_error, .rx_extended, .rx_id, .rx_remote, .rx_dlc, .rx_data_hit,
    .bus_idle
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Pulse is one cycle, so counting edges counts frames
  always @(posedge clk) if (wake_frame_valid === 1'b1) wakes <= wakes + 1;

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [28:0] field(input logic [7:0] b [4], input logic e);
    return e ? {b[3][4:0], b[2], b[1], b[0]} : {18'h0_0000, b[3][4:0], b[2][7:2]};
  endfunction : field

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    reg_addr = a;
    cyc(1);
    d = reg_rdata;
  endtask : rd

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Sequence
  initial begin
    logic [7:0] d, q;
    logic [7:0] p [4];
    logic [7:0] m [4];
    logic [28:0] pt, mk, fl;
    logic [31:0] r;
    logic e;
    int w, k;
    seed = 32'h0000_bdf1;
    {reg_wr, reg_addr, reg_wdata, selective_wake_active, fd_tolerance_enable} = '0;
    {filter_config_set, frame_error_clear, pn_restart} = '0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    #2;
    rst = 1'b0;
    cyc(1);
    // Reset values, unmapped place reads zero
    for (logic [6:0] a = 7'h26; a <= 7'h30; a++) begin
      rd(a, d);
      chk("reset_value", d, a == 7'h26 ? 8'h05 : a == 7'h2F ? 8'h40 : 8'h00);
    end
    chk("reset_rate", arbitration_rate_kbps, 11'h1F4);
    for (int c = 0; c < 8; c++) begin
      d = 8'(rnd());
      wr(`CSWF_ADDR_RATE, {d[7:3], c[2:0]});
      chk("rate_kbps", arbitration_rate_kbps, rates[c]);
      rd(`CSWF_ADDR_RATE, q);
      chk("rate_reg", q, {5'h00, c[2:0]});
    end
    pulse(filter_config_set);
    chk("cfg_set", filter_config_valid, 1'b1);
    for (int i = 0; i < 8; i++) begin
      d = 8'(rnd());
      wr(`CSWF_ADDR_ID0 + 7'(i), d);
      chk("cfg_cleared", filter_config_valid, 1'b0);
      rd(`CSWF_ADDR_ID0 + 7'(i), q);
      chk("id_mask_reg", q, i % 4 == 3 ? d & 8'h1F : d);
    end
    for (int i = 0; i < 16; i++) begin
      d = 8'(rnd());
      wr(`CSWF_ADDR_FRAME_CTRL, {d[7:4], i[3:0]});
      rd(`CSWF_ADDR_FRAME_CTRL, q);
      chk("frame_ctrl", q, {d[7:6], 2'b00, i[3:0]});
      chk("exp_bytes", expected_bytes, i > 8 ? 4'h8 : i[3:0]);
    end
    // Error counter and FD handling
    selective_wake_active = 1'b1;
    pulse(pn_restart);
    for (int i = 0; i < 4; i++) cswf_bus_node_inst.frame(1'b0, 29'h0000_0000, 1'b0, 4'h0, 1'b0, i < 3);
    chk("err_updown", err_count, 6'h02);
    fd_tolerance_enable = 1'b1;
    cswf_bus_node_inst.fd_frame(1'b0, 29'h0000_0000, 4'h0);
    chk("fd_ignore", fd_ignoring, 1'b1);
    chk("fd_tolerated", err_count, 6'h01);
    chk("fd_asleep", wake_request, 1'b0);
    cswf_bus_node_inst.idle();
    chk("fd_idle", fd_ignoring, 1'b0);
    fd_tolerance_enable = 1'b0;
    cswf_bus_node_inst.fd_frame(1'b0, 29'h0000_0000, 4'h0);
    cswf_bus_node_inst.idle();
    chk("fd_counted", err_count, 6'h02);
    pulse(pn_restart);
    for (int i = 0; i < 32; i++) begin
      if (i == 31) chk("err_limit", err_count, 6'h1F);
      if (i == 31) chk("no_early_flag", frame_detect_error_flag, 1'b0);
      cswf_bus_node_inst.fd_frame(1'b0, 29'h0000_0000, 4'h0);
      cswf_bus_node_inst.idle();
    end
    chk("fde_flag", frame_detect_error_flag, 1'b1);
    chk("fde_wake", wake_request, 1'b1);
    rd(`CSWF_ADDR_STATUS, q);
    chk("status", q, 8'h06);
    pulse(frame_error_clear);
    chk("fde_clear", frame_detect_error_flag, 1'b0);
    pulse(pn_restart);
    // Wake frame matching, last three with data filter on
    for (int i = 0; i < 27; i++) begin
      for (int b = 0; b < 4; b++) begin
        p[b] = 8'(rnd() >> 3);
        m[b] = 8'(rnd() >> 5) & 8'(rnd());
        wr(`CSWF_ADDR_ID0 + 7'(b), p[b]);
        wr(`CSWF_ADDR_MASK0 + 7'(b), m[b]);
      end
      r = rnd();
      e = r[9];
      k = i - 24;
      wr(`CSWF_ADDR_FRAME_CTRL, i < 24 ? {e, 7'h00} : {e, 3'b100, k == 2 ? 4'h9 : 4'h3});
      pulse(filter_config_set);
      pt = field(p, e);
      mk = field(m, e);
      fl = r[28:0] & (e ? 29'h1FFF_FFFF : 29'h0000_07FF);
      if (r[31]) fl = fl & mk;
      w = wakes;
      cswf_bus_node_inst.frame(e, pt ^ fl, i < 24 && r[30], i < 24 ? 4'h0 : k == 1 ? 4'h2 : k == 2 ? 4'hF : 4'h3,
                               1'b1, 1'b0);
      chk("wake_match", wakes - w, ((fl & ~mk) == 0 && k != 1) ? 1 : 0);
      w = wakes;
      cswf_bus_node_inst.frame(~e, pt, 1'b0, 4'h0, 1'b1, 1'b0);
      cswf_bus_node_inst.fd_frame(e, pt, k == 2 ? 4'h9 : 4'h3);
      cswf_bus_node_inst.idle();
      chk("no_wake", wakes - w, 0);
    end
    report_and_stop();
  end
endmodule : tb_cswf_top
`default_nettype wire
